// ==== logic/ipr3_params.svh ====
// Offsets, field positions, reset values and codes of the priority register
`ifndef IPR3_PARAMS_SVH
`define IPR3_PARAMS_SVH
`define IPR3_CTRL_OFFSET 32'h0000_0000
`define IPR3_CN_LSB 12
`define IPR3_CM_LSB 8
`define IPR3_SM_LSB 4
`define IPR3_SS_LSB 0
`define IPR3_FIELD_RESET 3'h4
`define IPR3_CODE_OFF 3'h0
`define IPR3_REG_MASK 16'h7777
`define IPR3_REG_RESET 16'h4444
`define IPR3_ADDR_LSBS 2
`endif

// ==== logic/ipr3_pkg.sv ====
// Types shared by the priority register block
package ipr3_pkg;
  typedef logic [2:0] ipr3_level_t;
  typedef logic [15:0] ipr3_word_t;
  typedef enum logic {IPR3_IDLE, IPR3_WRITE} ipr3_phase_t;
endpackage : ipr3_pkg

// ==== logic/ipr3_level_decode.sv ====
// Turns one priority field and its source request into a level and a request
`timescale 1ns/1ns
`default_nettype none
`include "ipr3_params.svh"
module ipr3_level_decode (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Field and source
  input wire ipr3_pkg::ipr3_level_t code,
  input wire logic src_req,
  // Result
  output logic req_out,
  output ipr3_pkg::ipr3_level_t level_out
);
  logic req_reg;
  logic req_next;
  ipr3_pkg::ipr3_level_t level_reg;
  ipr3_pkg::ipr3_level_t level_next;

  always_comb begin
    // Code maps straight onto levels 1..7; zero disables
    level_next = code;
    req_next = src_req && (code != `IPR3_CODE_OFF);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= 1'b0;
      level_reg <= `IPR3_FIELD_RESET;
    end else begin
      req_reg <= req_next;
      level_reg <= level_next;
    end
  end

  assign req_out = req_reg;
  assign level_out = level_reg;

  property p_off_no_req;
    @(posedge hclk) disable iff (!hresetn)
    (code == `IPR3_CODE_OFF) |=> !req_reg;
  endproperty
  a_off_no_req: assert property (p_off_no_req) else $error("disabled source requested");

  property p_level_follows;
    @(posedge hclk) disable iff (!hresetn)
    (code != `IPR3_CODE_OFF) && src_req |=> req_reg && (level_reg == $past(code));
  endproperty
  a_level_follows: assert property (p_level_follows) else $error("level not taken from code");

  property p_top_level;
    @(posedge hclk) disable iff (!hresetn)
    (code == 3'h7) |=> (level_reg == 3'h7);
  endproperty
  a_top_level: assert property (p_top_level) else $error("code 7 not level 7");
endmodule : ipr3_level_decode
`default_nettype wire

// ==== logic/ipr3_top.sv ====
// AHB-Lite priority control register three with per-source level outputs
// ----------------------------------------
// Functional notes
// - Change-notify priority field in bits 14:12, reset 100
// - Comparator priority field in bits 10:8, reset 100
// - Serial master priority field bits 6:4, reset 100
// - Serial slave priority field bits 2:0, reset 100
// - Code 111 gives level 7, highest
// - Code 001 is level 1; others linear
// - Code 000 disables the source entirely
// - Bits 15, 11, 7, 3 read zero, unwritable
// ----------------------------------------
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "ipr3_params.svh"
module ipr3_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Source requests, same clock
  input wire logic [3:0] src_req,
  // Per-source request and level, order cn, cm, sm, ss
  output logic [3:0] prio_req,
  output logic [11:0] prio_level
);
  // ----------------------------------------
  // Bus phase tracking
  // ----------------------------------------
  ipr3_pkg::ipr3_phase_t phase_reg;
  ipr3_pkg::ipr3_phase_t phase_next;
  logic hit_reg;
  logic hit_next;
  logic addr_hit;
  logic take;

  assign take = hsel && hready && htrans[1];
  assign addr_hit = (haddr[31:`IPR3_ADDR_LSBS] == 30'(`IPR3_CTRL_OFFSET >> `IPR3_ADDR_LSBS));

  always_comb begin
    phase_next = ipr3_pkg::IPR3_IDLE;
    hit_next = 1'b0;
    if (take) begin
      hit_next = addr_hit;
      if (hwrite) begin
        phase_next = ipr3_pkg::IPR3_WRITE;
      end
    end
  end

  // ----------------------------------------
  // Priority register
  // ----------------------------------------
  ipr3_pkg::ipr3_word_t prio_reg;
  ipr3_pkg::ipr3_word_t prio_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  always_comb begin
    prio_next = prio_reg;
    if (phase_reg == ipr3_pkg::IPR3_WRITE && hit_reg) begin
      prio_next = hwdata[15:0] & `IPR3_REG_MASK;
    end
    rdata_next = 32'h0000_0000;
    if (take && !hwrite && addr_hit) begin
      rdata_next = {16'h0000, prio_next & `IPR3_REG_MASK};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= ipr3_pkg::IPR3_IDLE;
      hit_reg <= 1'b0;
      prio_reg <= `IPR3_REG_RESET;
      rdata_reg <= 32'h0000_0000;
    end else begin
      phase_reg <= phase_next;
      hit_reg <= hit_next;
      prio_reg <= prio_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------
  // Level decode per source
  // ----------------------------------------
  ipr3_level_decode u_cn (
    .hclk(hclk),
    .hresetn(hresetn),
    .code(prio_reg[`IPR3_CN_LSB +: 3]),
    .src_req(src_req[3]),
    .req_out(prio_req[3]),
    .level_out(prio_level[11:9])
  );
  ipr3_level_decode u_cm (
    .hclk(hclk),
    .hresetn(hresetn),
    .code(prio_reg[`IPR3_CM_LSB +: 3]),
    .src_req(src_req[2]),
    .req_out(prio_req[2]),
    .level_out(prio_level[8:6])
  );
  ipr3_level_decode u_sm (
    .hclk(hclk),
    .hresetn(hresetn),
    .code(prio_reg[`IPR3_SM_LSB +: 3]),
    .src_req(src_req[1]),
    .req_out(prio_req[1]),
    .level_out(prio_level[5:3])
  );
  ipr3_level_decode u_ss (
    .hclk(hclk),
    .hresetn(hresetn),
    .code(prio_reg[`IPR3_SS_LSB +: 3]),
    .src_req(src_req[0]),
    .req_out(prio_req[0]),
    .level_out(prio_level[2:0])
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_unimpl_zero;
    @(posedge hclk) disable iff (!hresetn)
    (prio_reg & ~`IPR3_REG_MASK) == 16'h0000 && hrdata[31:16] == 16'h0000 && (hrdata[15:0] & 16'h8888) == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_write_cn;
    @(posedge hclk) disable iff (!hresetn)
    (phase_reg == ipr3_pkg::IPR3_WRITE && hit_reg) |=> prio_reg[14:12] == $past(hwdata[14:12]);
  endproperty
  a_write_cn: assert property (p_write_cn) else $error("change-notify field not written");

  property p_write_cm;
    @(posedge hclk) disable iff (!hresetn)
    (phase_reg == ipr3_pkg::IPR3_WRITE && hit_reg) |=> prio_reg[10:8] == $past(hwdata[10:8]);
  endproperty
  a_write_cm: assert property (p_write_cm) else $error("comparator field not written");

  property p_write_sm;
    @(posedge hclk) disable iff (!hresetn)
    (phase_reg == ipr3_pkg::IPR3_WRITE && hit_reg) |=> prio_reg[6:4] == $past(hwdata[6:4]);
  endproperty
  a_write_sm: assert property (p_write_sm) else $error("serial master field not written");

  property p_write_ss;
    @(posedge hclk) disable iff (!hresetn)
    (phase_reg == ipr3_pkg::IPR3_WRITE && hit_reg) |=> prio_reg[2:0] == $past(hwdata[2:0]);
  endproperty
  a_write_ss: assert property (p_write_ss) else $error("serial slave field not written");

  property p_read_back;
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && addr_hit && phase_reg == ipr3_pkg::IPR3_IDLE |=> hrdata == {16'h0000, prio_reg};
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    phase_reg != ipr3_pkg::IPR3_WRITE |=> prio_reg == $past(prio_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  property p_ss_off;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[2:0] == 3'h0 ##1 prio_reg[2:0] == 3'h0 |-> !prio_req[0];
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("disabled slave source requested");

  property p_cn_top;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[14:12] == 3'h7 |=> prio_level[11:9] == 3'h7;
  endproperty
  a_cn_top: assert property (p_cn_top) else $error("level 7 not reported");

  property p_cm_top;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[10:8] == 3'h7 |=> prio_level[8:6] == 3'h7;
  endproperty
  a_cm_top: assert property (p_cm_top) else $error("comparator level 7 not reported");

  property p_sm_top;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[6:4] == 3'h7 |=> prio_level[5:3] == 3'h7;
  endproperty
  a_sm_top: assert property (p_sm_top) else $error("serial master level 7 not reported");

  property p_ss_top;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[2:0] == 3'h7 |=> prio_level[2:0] == 3'h7;
  endproperty
  a_ss_top: assert property (p_ss_top) else $error("serial slave level 7 not reported");

  property p_cn_low;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[14:12] == 3'h1 |=> prio_level[11:9] == 3'h1;
  endproperty
  a_cn_low: assert property (p_cn_low) else $error("change-notify level 1 not reported");

  property p_cm_low;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[10:8] == 3'h1 |=> prio_level[8:6] == 3'h1;
  endproperty
  a_cm_low: assert property (p_cm_low) else $error("comparator level 1 not reported");

  property p_sm_low;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[6:4] == 3'h1 |=> prio_level[5:3] == 3'h1;
  endproperty
  a_sm_low: assert property (p_sm_low) else $error("serial master level 1 not reported");

  property p_ss_low;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[2:0] == 3'h1 |=> prio_level[2:0] == 3'h1;
  endproperty
  a_ss_low: assert property (p_ss_low) else $error("serial slave level 1 not reported");

  property p_cn_off;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[14:12] == 3'h0 |=> !prio_req[3];
  endproperty
  a_cn_off: assert property (p_cn_off) else $error("disabled change-notify source requested");

  property p_cm_off;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[10:8] == 3'h0 |=> !prio_req[2];
  endproperty
  a_cm_off: assert property (p_cm_off) else $error("disabled comparator source requested");

  property p_sm_off;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[6:4] == 3'h0 |=> !prio_req[1];
  endproperty
  a_sm_off: assert property (p_sm_off) else $error("disabled serial master source requested");

  property p_reset_cn;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> prio_reg[`IPR3_CN_LSB +: 3] == `IPR3_FIELD_RESET;
  endproperty
  a_reset_cn: assert property (p_reset_cn) else $error("change-notify field reset wrong");

  property p_reset_cm;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> prio_reg[`IPR3_CM_LSB +: 3] == `IPR3_FIELD_RESET;
  endproperty
  a_reset_cm: assert property (p_reset_cm) else $error("comparator field reset wrong");

  property p_reset_sm;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> prio_reg[`IPR3_SM_LSB +: 3] == `IPR3_FIELD_RESET;
  endproperty
  a_reset_sm: assert property (p_reset_sm) else $error("serial master field reset wrong");

  property p_reset_ss;
    @(posedge hclk) disable iff (!hresetn)
    $rose(hresetn) |-> prio_reg[`IPR3_SS_LSB +: 3] == `IPR3_FIELD_RESET;
  endproperty
  a_reset_ss: assert property (p_reset_ss) else $error("serial slave field reset wrong");

  property p_en_cn;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[14:12] != 3'h0 && src_req[3] |=> prio_req[3] && prio_level[11:9] == $past(prio_reg[14:12]);
  endproperty
  a_en_cn: assert property (p_en_cn) else $error("change-notify field not routed");

  property p_en_cm;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[10:8] != 3'h0 && src_req[2] |=> prio_req[2] && prio_level[8:6] == $past(prio_reg[10:8]);
  endproperty
  a_en_cm: assert property (p_en_cm) else $error("comparator field not routed");

  property p_en_sm;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[6:4] != 3'h0 && src_req[1] |=> prio_req[1] && prio_level[5:3] == $past(prio_reg[6:4]);
  endproperty
  a_en_sm: assert property (p_en_sm) else $error("serial master field not routed");

  property p_en_ss;
    @(posedge hclk) disable iff (!hresetn)
    prio_reg[2:0] != 3'h0 && src_req[0] |=> prio_req[0] && prio_level[2:0] == $past(prio_reg[2:0]);
  endproperty
  a_en_ss: assert property (p_en_ss) else $error("serial slave field not routed");

  property p_read_idle;
    @(posedge hclk) disable iff (!hresetn)
    !(take && !hwrite && addr_hit) |=> hrdata == 32'h0000_0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside data phase");

  c_write: cover property (@(posedge hclk) disable iff (!hresetn) phase_reg == ipr3_pkg::IPR3_WRITE && hit_reg);
  c_read: cover property (@(posedge hclk) disable iff (!hresetn) take && !hwrite && addr_hit);
  c_off: cover property (@(posedge hclk) disable iff (!hresetn) prio_reg[14:12] == 3'h0 && src_req[3]);
  c_top: cover property (@(posedge hclk) disable iff (!hresetn) prio_req[1] && prio_level[5:3] == 3'h7);
  c_low: cover property (@(posedge hclk) disable iff (!hresetn) prio_req[0] && prio_level[2:0] == 3'h1);
endmodule : ipr3_top
`default_nettype wire

// ==== dv/ipr3_bench.sv ====
// Self-checking bench for the priority register over AHB-Lite
`timescale 1ns/1ns
`default_nettype none
`include "ipr3_params.svh"
module ipr3_bench;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd_val;
  logic [1:0] htrans;
  logic [2:0] hsize, c3;
  logic [3:0] src_req;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic [3:0] prio_req;
  logic [11:0] prio_level;
  int fails = 0;
  int total_checks = 0;

  ipr3_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src_req(src_req), .prio_req(prio_req),
    .prio_level(prio_level));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    #100000;
    fails++;
    results();
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : check

  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      $display("[ERR] hreadyout expected 1 seen %b", hreadyout);
      results();
    end
  endtask : rdy

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd_val = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    src_req = 4'hF;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `IPR3_CTRL_OFFSET, 32'h0);
    check("reset reg", 32'h0000_4444, rd_val);
    check("reset level", 32'h0000_0924, {20'h0, prio_level});
    check("reset req", 32'h0000_000F, {28'h0, prio_req});
    for (int c = 0; c < 8; c++) begin
      c3 = c[2:0];
      xfer(1'b1, `IPR3_CTRL_OFFSET, {16'hFFFF, {4{1'b1, c3}}});
      xfer(1'b0, `IPR3_CTRL_OFFSET, 32'h0);
      check("code reg", {16'h0, {4{1'b0, c3}}}, rd_val);
      check("code level", {20'h0, {4{c3}}}, {20'h0, prio_level});
      check("code req", {28'h0, (c3 != 3'h0) ? 4'hF : 4'h0}, {28'h0, prio_req});
    end
    src_req <= 4'hB;
    xfer(1'b1, `IPR3_CTRL_OFFSET, 32'h0000_8F19);
    xfer(1'b0, `IPR3_CTRL_OFFSET, 32'h0);
    check("mixed reg", 32'h0000_0711, rd_val);
    check("mixed level", 32'h0000_01C9, {20'h0, prio_level});
    check("mixed req", 32'h0000_0003, {28'h0, prio_req});
    xfer(1'b1, 32'h0000_0010, 32'h0000_7777);
    xfer(1'b0, 32'h0000_0010, 32'h0);
    check("unmapped read", 32'h0, rd_val);
    xfer(1'b0, `IPR3_CTRL_OFFSET, 32'h0);
    check("reg kept", 32'h0000_0711, rd_val);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, `IPR3_CTRL_OFFSET, 32'h0);
    check("second reset reg", 32'h0000_4444, rd_val);
    check("second reset level", 32'h0000_0924, {20'h0, prio_level});
    results();
  end
endmodule : ipr3_bench
`default_nettype wire
